// *** design/ac_output_sequencer_control.sv ***
// AC output sequencer control: states, trigger handling, modes and register port
// Summary of operation
// - After reset the sequencer sits in idle.
// - Idle ignores every trigger from any source.
// - Abort, device reset or recall command forces idle from any state.
// - Host initiate moves idle to initiated; only initiated accepts a starting trigger.
// - With continuous set, completion returns straight to initiated.
// - Abort with continuous set still ends in idle.
// - Abort halts any running sequence at once.
// - Triggers come from external rising edge, front panel or bus command.
// - Only the selected trigger source or an immediate trigger command starts a sequence.
// - Active-high trigger output with modes off, trigger, frequency strobe.
// - Accepted trigger waits out the programmed delay before execution.
// - Immediate trigger command skips the delay.
// - Immediate mode applies a newly written base value at once.
// - Step mode moves to triggered values at start phase with slew, then holds.
// - Pulse active period drives triggered values for active duration from start phase.
// - Pulse ends at end phase then reverts to base for inactive duration.
// - Pulse active period repeats exactly the programmed count.
// - Pulse and list changes follow programmed slew rates.
// - List entries apply own levels, slew, phases and duration in order.
// - List runs programmed repetitions, continuously or one entry per trigger.
// - Completion applies the programmed end behaviour to the output in every mode but immediate.
// - Definitions can be saved into and restored from numbered memory cells.
`timescale 1ns/10ps
module ac_output_sequencer_control
  import seq_pkg::*;
(
  input wire logic clk, // 200 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [AW-1:0] addr, // Register address
  input wire logic [DW-1:0] wdata, // Register write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [DW-1:0] rdata, // Read data, cycle after rd
  input wire logic extTrig, // External trigger input
  input wire logic panelTrig, // Front-panel trigger pulse
  input wire logic [VW-1:0] phaseNow, // Present waveform phase
  output logic [VW-1:0] acLevel, // Output AC level
  output logic [VW-1:0] dcOffset, // Output DC offset
  output logic [VW-1:0] outFreq, // Output frequency
  output logic trigOut // Trigger output, active high
);
  seq_state_t state;
  logic [CTRL_W-1:0] ctrlReg;
  logic [VW-1:0] baseV [3];
  logic [VW-1:0] defV [NDEF];
  logic [VW-1:0] delayReg;
  logic [VW-1:0] listV [NENT][NLST];
  logic [IW-1:0] listSel;
  logic [IW:0] listLen;
  logic [DEFW-1:0] cells [NCELL];
  logic [VW-1:0] tgt [3];
  logic [VW-1:0] slewCur [3];
  logic [VW-1:0] outV [3];
  logic [VW-1:0] timer;
  logic [VW-1:0] repLeft;
  logic [IW-1:0] idx;
  logic [7:0] tickCnt;
  logic tick, extPrev, snapReq, startEv;
  logic [VW-1:0] freqPrev;

  // Field and command decode
  wire contFlag = ctrlReg[CTRL_CONT];
  wire seq_mode_t modeSel = seq_mode_t'(ctrlReg[CTRL_MODE +: 2]);
  wire trig_src_t srcSel = trig_src_t'(ctrlReg[CTRL_SRC +: 2]);
  wire trig_out_mode_t toutSel = trig_out_mode_t'(ctrlReg[CTRL_TOUT +: 2]);
  wire endBase = ctrlReg[CTRL_END];
  wire listStep = ctrlReg[CTRL_LSTEP];
  wire cmdWr = wr && (addr == OFS_CMD);
  wire cmdInit = cmdWr && wdata[CMD_INIT];
  wire cmdAbort = cmdWr && wdata[CMD_ABORT];
  wire goIdle = cmdWr && (wdata[CMD_ABORT] || wdata[CMD_RESET] || wdata[CMD_RECALL]);
  wire immHit = cmdWr && wdata[CMD_TRIG_IMM];
  wire [CW-1:0] cellSel = wdata[CMD_CELL +: CW];
  wire isIdle = (state == ST_IDLE);
  wire armed = (state == ST_INIT) || (state == ST_LWAIT);
  wire extEdge = extTrig && !extPrev;

  // Only the selected source counts as a trigger
  logic trigHit;
  always_comb begin
    case (srcSel)
      SRC_EXT: trigHit = extEdge;
      SRC_PANEL: trigHit = panelTrig;
      SRC_BUS: trigHit = cmdWr && wdata[CMD_TRIG];
      default: trigHit = 1'b0;
    endcase
  end

  // Phase target depends on mode and list entry
  wire [VW-1:0] startPh = (modeSel == MODE_LIST) ? listV[idx][LST_START] : defV[DEF_START_PH];
  wire [VW-1:0] endPh = (modeSel == MODE_LIST) ? listV[idx][LST_END] : defV[DEF_END_PH];

  // Microsecond tick divider
  always_ff @(posedge clk) begin
    if (rst) begin
      tickCnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= (tickCnt == TICK_LAST);
      tickCnt <= (tickCnt == TICK_LAST) ? 8'h00 : tickCnt + 8'h01;
    end
  end

  // External trigger edge memory
  always_ff @(posedge clk) begin
    if (rst) extPrev <= 1'b0;
    else extPrev <= extTrig;
  end

  // Configuration: definitions only change while idle, so a running sequence stays coherent
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlReg <= CTRL_RST;
      delayReg <= 16'h0000;
      listSel <= '0;
      listLen <= 4'h1;
      for (int i = 0; i < 3; i++) baseV[i] <= 16'h0000;
      for (int i = 0; i < NDEF; i++) defV[i] <= 16'h0000;
    end else if (wr) begin
      if (addr == OFS_CTRL) ctrlReg <= wdata[CTRL_W-1:0];
      for (int i = 0; i < 3; i++)
        if (addr == OFS_BASE_AC + 8'(4 * i)) baseV[i] <= wdata[VW-1:0];
      if (isIdle) begin
        if (addr == OFS_DELAY) delayReg <= wdata[VW-1:0];
        if (addr == OFS_LIST_SEL) listSel <= wdata[IW-1:0];
        if (addr == OFS_LIST_LEN && wdata[IW:0] != 4'h0 && wdata[IW:0] <= 4'(NENT))
          listLen <= wdata[IW:0];
        for (int i = 0; i < NDEF; i++)
          if (addr == OFS_DEF0 + 8'(4 * i)) defV[i] <= wdata[VW-1:0];
        if (cmdWr && wdata[CMD_RESTORE])
          for (int i = 0; i < NDEF; i++) defV[i] <= cells[cellSel][i * VW +: VW];
      end
    end
  end

  // List table and memory cells are plain arrays with no reset
  always_ff @(posedge clk) begin
    if (wr && isIdle)
      for (int i = 0; i < NLST; i++)
        if (addr == OFS_LIST0 + 8'(4 * i)) listV[listSel][i] <= wdata[VW-1:0];
    if (cmdWr && wdata[CMD_SAVE])
      for (int i = 0; i < NDEF; i++) cells[cellSel][i * VW +: VW] <= defV[i];
  end

  // Sequencer state machine
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      timer <= 16'h0000;
      repLeft <= 16'h0000;
      idx <= '0;
      snapReq <= 1'b0;
      startEv <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        tgt[i] <= 16'h0000;
        slewCur[i] <= 16'h0000;
      end
    end else begin
      snapReq <= 1'b0;
      startEv <= 1'b0;
      // Immediate mode writes go straight to the output, bypassing slew
      if (modeSel == MODE_IMM)
        for (int i = 0; i < 3; i++)
          if (wr && addr == OFS_BASE_AC + 8'(4 * i)) begin
            tgt[i] <= wdata[VW-1:0];
            snapReq <= 1'b1;
          end
      if (goIdle) begin
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: if (cmdInit) state <= ST_INIT;
          ST_INIT: begin
            if (immHit) state <= ST_START;
            else if (trigHit) begin
              timer <= delayReg;
              state <= (delayReg == 16'h0000) ? ST_START : ST_DELAY;
            end
          end
          ST_DELAY: begin
            if (immHit || timer == 16'h0000) state <= ST_START;
            else if (tick) timer <= timer - 16'h0001;
          end
          ST_START: begin
            startEv <= 1'b1;
            idx <= '0;
            repLeft <= defV[DEF_COUNT];
            if (modeSel == MODE_IMM) state <= ST_DONE;
            else if (modeSel != MODE_STEP && defV[DEF_COUNT] == 16'h0000) state <= ST_DONE;
            else state <= ST_PHWAIT;
          end
          ST_PHWAIT: begin
            if (phaseNow == startPh) begin
              if (modeSel == MODE_LIST) begin
                for (int i = 0; i < 3; i++) begin
                  tgt[i] <= listV[idx][LST_AC + i];
                  slewCur[i] <= listV[idx][LST_SLEW];
                end
                timer <= listV[idx][LST_DUR];
              end else begin
                for (int i = 0; i < 3; i++) begin
                  tgt[i] <= defV[DEF_TRIG_AC + i];
                  slewCur[i] <= defV[DEF_SLEW_AC + i];
                end
                timer <= defV[DEF_ACT];
              end
              state <= (modeSel == MODE_STEP) ? ST_DONE : ST_ACT;
            end
          end
          ST_ACT: begin
            if (timer == 16'h0000) state <= ST_ENDPH;
            else if (tick) timer <= timer - 16'h0001;
          end
          ST_ENDPH: begin
            if (phaseNow == endPh) begin
              if (modeSel == MODE_PULSE) begin
                for (int i = 0; i < 3; i++) tgt[i] <= baseV[i];
                timer <= defV[DEF_INACT];
                state <= ST_INACT;
              end else if ({1'b0, idx} == listLen - 4'h1) begin
                idx <= '0;
                repLeft <= repLeft - 16'h0001;
                if (repLeft == 16'h0001) state <= ST_DONE;
                else state <= listStep ? ST_LWAIT : ST_PHWAIT;
              end else begin
                idx <= idx + 1'b1;
                state <= listStep ? ST_LWAIT : ST_PHWAIT;
              end
            end
          end
          ST_INACT: begin
            if (timer == 16'h0000) begin
              repLeft <= repLeft - 16'h0001;
              state <= (repLeft == 16'h0001) ? ST_DONE : ST_PHWAIT;
            end else if (tick) timer <= timer - 16'h0001;
          end
          ST_LWAIT: if (trigHit || immHit) state <= ST_PHWAIT;
          ST_DONE: begin
            if (endBase && modeSel != MODE_IMM)
              for (int i = 0; i < 3; i++) tgt[i] <= baseV[i];
            state <= contFlag ? ST_INIT : ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Slew engines, one per output quantity; a zero rate means jump in one tick
  for (genvar ch = 0; ch < 3; ch++) begin : g_slew
    always_ff @(posedge clk) begin
      if (rst) outV[ch] <= 16'h0000;
      else if (snapReq) outV[ch] <= tgt[ch];
      else if (tick && outV[ch] != tgt[ch]) begin
        if (slewCur[ch] == 16'h0000) outV[ch] <= tgt[ch];
        else if (outV[ch] < tgt[ch])
          outV[ch] <= (tgt[ch] - outV[ch] > slewCur[ch]) ? outV[ch] + slewCur[ch] : tgt[ch];
        else
          outV[ch] <= (outV[ch] - tgt[ch] > slewCur[ch]) ? outV[ch] - slewCur[ch] : tgt[ch];
      end
    end
  end
  assign acLevel = outV[0];
  assign dcOffset = outV[1];
  assign outFreq = outV[2];

  // Trigger output: start pulse, or a strobe whenever the output frequency moves
  always_ff @(posedge clk) begin
    if (rst) begin
      trigOut <= 1'b0;
      freqPrev <= 16'h0000;
    end else begin
      freqPrev <= outV[2];
      case (toutSel)
        TOUT_TRIG: trigOut <= startEv;
        TOUT_FREQUENCY_STROBE_OUT_MODE: trigOut <= (outV[2] != freqPrev);
        default: trigOut <= 1'b0;
      endcase
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (rst) rdata <= 32'h0000_0000;
    else if (rd) begin
      rdata <= 32'h0000_0000;
      if (addr == OFS_CTRL) rdata <= {23'h000000, ctrlReg};
      if (addr == OFS_STATUS) rdata <= {repLeft, 9'h000, idx, 4'(state)};
      if (addr == OFS_DELAY) rdata <= {16'h0000, delayReg};
      if (addr == OFS_LIST_SEL) rdata <= {29'h00000000, listSel};
      if (addr == OFS_LIST_LEN) rdata <= {28'h0000000, listLen};
      for (int i = 0; i < 3; i++) begin
        if (addr == OFS_BASE_AC + 8'(4 * i)) rdata <= {16'h0000, baseV[i]};
        if (addr == OFS_OUT_AC + 8'(4 * i)) rdata <= {16'h0000, outV[i]};
      end
      for (int i = 0; i < NDEF; i++)
        if (addr == OFS_DEF0 + 8'(4 * i)) rdata <= {16'h0000, defV[i]};
      for (int i = 0; i < NLST; i++)
        if (addr == OFS_LIST0 + 8'(4 * i)) rdata <= {16'h0000, listV[listSel][i]};
    end
  end

  // Checks on the state machine
  AST_RESET_IDLE: assert property (@(posedge clk) rst |=> state == ST_IDLE)
    else $error("not idle after reset");
  AST_IDLE_IGNORES: assert property (@(posedge clk) disable iff (rst)
    (isIdle && !cmdInit) |=> isIdle) else $error("left idle without initiate");
  AST_FORCE_IDLE: assert property (@(posedge clk) disable iff (rst)
    goIdle |=> isIdle ##1 (isIdle || state == ST_INIT)) else $error("abort did not idle");
  AST_START_FROM_ARMED: assert property (@(posedge clk) disable iff (rst)
    (state == ST_START) |-> ($past(state) == ST_INIT || $past(state) == ST_DELAY))
    else $error("start without initiated state");
  AST_CONT_REARM: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DONE && contFlag && !goIdle) |=> state == ST_INIT)
    else $error("continuous did not rearm");
  AST_ABORT_CONT: assert property (@(posedge clk) disable iff (rst)
    (cmdAbort && contFlag) |=> (state == ST_IDLE) && !armed)
    else $error("abort with continuous not idle");
  AST_SOURCE_ONLY: assert property (@(posedge clk) disable iff (rst)
    (state == ST_INIT && !trigHit && !immHit && !goIdle) |=> state == ST_INIT)
    else $error("unselected source started sequence");
  AST_DELAY: assert property (@(posedge clk) disable iff (rst)
    (state == ST_INIT && trigHit && !immHit && !goIdle && delayReg != 16'h0000)
    |=> state == ST_DELAY) else $error("delay skipped");
  AST_IMM_TRIG: assert property (@(posedge clk) disable iff (rst)
    (armed && immHit && !goIdle) |=> (state == ST_START || state == ST_PHWAIT))
    else $error("immediate trigger delayed");
  AST_IMM_BASE: assert property (@(posedge clk) disable iff (rst)
    (modeSel == MODE_IMM && wr && addr == OFS_BASE_AC) |-> ##2 acLevel == $past(wdata[VW-1:0], 2))
    else $error("immediate base not applied");
  AST_DONE_IDLE: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DONE && !contFlag && !goIdle) |=> isIdle) else $error("no idle on completion");
  // Panel and external events must not start a bus-sourced sequence
  AST_UNSELECTED_IGNORED: assert property (@(posedge clk) disable iff (rst)
    (state == ST_INIT && srcSel == SRC_BUS && !cmdWr) |=> state == ST_INIT)
    else $error("trigger from unselected source accepted");
  AST_TRIG_OUT: assert property (@(posedge clk) disable iff (rst)
    (state == ST_START && !goIdle && toutSel == TOUT_TRIG) ##1 (toutSel == TOUT_TRIG)
    |=> trigOut) else $error("no trigger output pulse at start");
  COV_PULSE: cover property (@(posedge clk) disable iff (rst)
    (modeSel == MODE_PULSE && state == ST_INACT) ##[1:1000] state == ST_DONE);
  COV_LIST_STEP: cover property (@(posedge clk) disable iff (rst) state == ST_LWAIT);
  COV_STEP_DONE: cover property (@(posedge clk) disable iff (rst)
    (modeSel == MODE_STEP && state == ST_PHWAIT) ##1 state == ST_DONE);
endmodule : ac_output_sequencer_control

// *** design/seq_pkg.sv ***
// Constants, register map and types of the AC output sequencer control block
package seq_pkg;
  // Timing: the sequencer counts durations in ticks of one microsecond
  localparam int CLK_NS = 5;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

  // Widths and depths
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int VW = 16;
  localparam int NENT = 8;
  localparam int IW = 3;
  localparam int NCELL = 4;
  localparam int CW = 2;
  localparam int NDEF = 11;
  localparam int DEFW = NDEF * VW;

  // Register offsets (byte addresses, one word each)
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_CMD = 8'h04;
  localparam logic [AW-1:0] OFS_STATUS = 8'h08;
  localparam logic [AW-1:0] OFS_BASE_AC = 8'h0c;
  localparam logic [AW-1:0] OFS_BASE_DC = 8'h10;
  localparam logic [AW-1:0] OFS_BASE_FREQ = 8'h14;
  localparam logic [AW-1:0] OFS_DEF0 = 8'h18;
  localparam logic [AW-1:0] OFS_DELAY = 8'h44;
  localparam logic [AW-1:0] OFS_LIST_SEL = 8'h48;
  localparam logic [AW-1:0] OFS_LIST0 = 8'h4c;
  localparam logic [AW-1:0] OFS_LIST_LEN = 8'h68;
  localparam logic [AW-1:0] OFS_OUT_AC = 8'h6c;

  // Definition word slots at OFS_DEF0 + 4*slot
  localparam int DEF_TRIG_AC = 0;
  localparam int DEF_SLEW_AC = 3;
  localparam int DEF_START_PH = 6;
  localparam int DEF_END_PH = 7;
  localparam int DEF_ACT = 8;
  localparam int DEF_INACT = 9;
  localparam int DEF_COUNT = 10;
  // List entry word slots at OFS_LIST0 + 4*slot
  localparam int LST_AC = 0;
  localparam int LST_SLEW = 3;
  localparam int LST_START = 4;
  localparam int LST_END = 5;
  localparam int LST_DUR = 6;
  localparam int NLST = 7;

  // CTRL fields
  localparam int CTRL_CONT = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_SRC = 3;
  localparam int CTRL_TOUT = 5;
  localparam int CTRL_END = 7;
  localparam int CTRL_LSTEP = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  // CMD bits (write only, self clearing)
  localparam int CMD_INIT = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_RESET = 2;
  localparam int CMD_RECALL = 3;
  localparam int CMD_TRIG = 4;
  localparam int CMD_TRIG_IMM = 5;
  localparam int CMD_SAVE = 6;
  localparam int CMD_RESTORE = 7;
  localparam int CMD_CELL = 8;

  typedef enum logic [1:0] {MODE_IMM, MODE_STEP, MODE_PULSE, MODE_LIST} seq_mode_t;
  typedef enum logic [1:0] {SRC_EXT, SRC_PANEL, SRC_BUS, SRC_NONE} trig_src_t;
  typedef enum logic [1:0] {TOUT_OFF, TOUT_TRIG, TOUT_FREQUENCY_STROBE_OUT_MODE, TOUT_RSVD} trig_out_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_INIT, ST_DELAY, ST_START, ST_PHWAIT, ST_ACT, ST_ENDPH, ST_INACT,
    ST_LWAIT, ST_DONE
  } seq_state_t;
endpackage : seq_pkg

// *** tb/seq_far_side.sv ***
// Far side model: waveform phase generator and external trigger source
`timescale 1ns/10ps
module seq_far_side
  import seq_pkg::*;
#(
  parameter int PH_MOD = 64 // Short phase wrap so every value comes round quickly
) (
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic fire, // Bench request for one external trigger
  output logic extTrig, // External trigger line
  output logic [VW-1:0] phaseNow // Present phase, passes through every value
);
  logic [1:0] holdCnt_reg;

  // Phase ramps one step a cycle so an exact phase match is always reached
  always_ff @(posedge clk) begin
    if (rst || phaseNow == VW'(PH_MOD - 1)) begin
      phaseNow <= '0;
    end else begin
      phaseNow <= phaseNow + 16'h0001;
    end
  end

  // Trigger is a clean low-high-low pulse so the device sees one rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      holdCnt_reg <= 2'h0;
      extTrig <= 1'b0;
    end else begin
      if (fire) holdCnt_reg <= 2'h2;
      else if (holdCnt_reg != 2'h0) holdCnt_reg <= holdCnt_reg - 2'h1;
      extTrig <= (holdCnt_reg != 2'h0);
    end
  end
endmodule : seq_far_side

// *** tb/tb_top.sv ***
// Self-checking testbench for the AC output sequencer control block
`timescale 1ns/10ps
module tb_top;
  import seq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] addr = 8'h00;
  logic [DW-1:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic panelTrig = 1'b0;
  logic fire = 1'b0;
  logic extTrig;
  logic trigOut;
  logic [VW-1:0] phaseNow, acLevel, dcOffset, outFreq, prevAc;
  logic [DW-1:0] rdata, rdVal;
  int pulseCnt = 0;
  int toutCnt = 0;
  int miscompares = 0;
  int nTests = 0;
  int pulseBase, toutBase;

  always #2.5 clk = ~clk;

  ac_output_sequencer_control i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .extTrig(extTrig), .panelTrig(panelTrig),
    .phaseNow(phaseNow), .acLevel(acLevel), .dcOffset(dcOffset), .outFreq(outFreq),
    .trigOut(trigOut));
  seq_far_side i_far (.clk(clk), .rst(rst), .fire(fire), .extTrig(extTrig),
    .phaseNow(phaseNow));

  // Count entries into the pulse level and trigger output pulses
  always @(posedge clk) begin
    prevAc <= acLevel;
    if (acLevel === 16'h0100 && prevAc !== 16'h0100) pulseCnt <= pulseCnt + 1;
    if (trigOut === 1'b1) toutCnt <= toutCnt + 1;
  end

  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data appear in the cycle after the strobe and hold until the next read; sample there
  task automatic rd_reg(input logic [AW-1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rdVal = rdata;
  endtask : rd_reg

  task automatic kick(input bit ext);
    @(posedge clk);
    if (ext) fire <= 1'b1;
    else panelTrig <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    panelTrig <= 1'b0;
  endtask : kick

  task automatic chk_reg(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    nTests++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: read %h, expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk_reg

  task automatic chk_cnt(input int got, input int exp);
    nTests++;
    if (got != exp) begin
      $display("CHECK FAILED at %0t: counted %0d, expected %0d", $time, got, exp);
      miscompares++;
    end
  endtask : chk_cnt

  task automatic chk_state(input logic [3:0] s);
    rd_reg(OFS_STATUS);
    chk_reg(32'(rdVal[3:0]), 32'(s));
  endtask : chk_state

  // Bounded poll of the state field; running out ends the run
  task automatic wait_state(input logic [3:0] s);
    int n;
    n = 0;
    rd_reg(OFS_STATUS);
    while (rdVal[3:0] !== s && n < 3000) begin
      rd_reg(OFS_STATUS);
      n++;
    end
    if (n >= 3000) begin
      $display("CHECK FAILED at %0t: state %0d never reached", $time, s);
      miscompares++;
      complete_run();
    end
  endtask : wait_state

  function automatic logic [AW-1:0] defA(input int slot);
    return OFS_DEF0 + 8'(4 * slot);
  endfunction : defA

  // One list entry: levels, shared slew, zero phases, one tick of duration
  task automatic wr_ent(input logic [IW-1:0] e, input logic [VW-1:0] ac, dc, fr, sl);
    wr_reg(OFS_LIST_SEL, 32'(e));
    wr_reg(OFS_LIST0 + 8'(4 * LST_AC), 32'(ac));
    wr_reg(OFS_LIST0 + 8'(4 * (LST_AC + 1)), 32'(dc));
    wr_reg(OFS_LIST0 + 8'(4 * (LST_AC + 2)), 32'(fr));
    wr_reg(OFS_LIST0 + 8'(4 * LST_SLEW), 32'(sl));
    wr_reg(OFS_LIST0 + 8'(4 * LST_START), 32'h00000000);
    wr_reg(OFS_LIST0 + 8'(4 * LST_END), 32'h00000000);
    wr_reg(OFS_LIST0 + 8'(4 * LST_DUR), 32'h00000001);
  endtask : wr_ent

  function automatic logic [DW-1:0] mkCtrl(input int cont, mode, src, tout, endb);
    return 32'((cont << CTRL_CONT) | (mode << CTRL_MODE) | (src << CTRL_SRC)
      | (tout << CTRL_TOUT) | (endb << CTRL_END));
  endfunction : mkCtrl

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_state(4'h0);
    rd_reg(OFS_CTRL);
    chk_reg(rdVal, 32'h00000000);
    rd_reg(8'hfc);
    chk_reg(rdVal, 32'h00000000);
    // Immediate mode: a base write reaches the output with no trigger
    wr_reg(OFS_BASE_AC, 32'h00000011);
    repeat (2) @(posedge clk);
    rd_reg(OFS_OUT_AC);
    chk_reg(rdVal, 32'h00000011);
    // Idle: external and bus triggers are ignored
    wr_reg(defA(DEF_TRIG_AC), 32'h00001234);
    wr_reg(defA(DEF_START_PH), 32'h00000005);
    wr_reg(OFS_CTRL, mkCtrl(0, 1, 0, 1, 0));
    kick(1'b1);
    wr_reg(OFS_CTRL, mkCtrl(0, 1, 2, 1, 0));
    wr_reg(OFS_CMD, 32'h00000010);
    repeat (300) @(posedge clk);
    chk_state(4'h0);
    rd_reg(OFS_OUT_AC);
    chk_reg(rdVal, 32'h00000011);
    // Step: only the selected source starts it, then values are held
    wr_reg(OFS_CMD, 32'h00000001);
    chk_state(4'h1);
    kick(1'b0);
    kick(1'b1);
    repeat (20) @(posedge clk);
    chk_state(4'h1);
    toutBase = toutCnt;
    wr_reg(OFS_CMD, 32'h00000010);
    wait_state(4'h0);
    repeat (210) @(posedge clk);
    rd_reg(OFS_OUT_AC);
    chk_reg(rdVal, 32'h00001234);
    chk_cnt(toutCnt - toutBase, 1);
    // Continuous: completion lands back in initiated, abort still idles
    wr_reg(defA(DEF_TRIG_AC), 32'h00000222);
    wr_reg(OFS_CTRL, mkCtrl(1, 1, 2, 0, 0));
    wr_reg(OFS_CMD, 32'h00000001);
    wr_reg(OFS_CMD, 32'h00000010);
    repeat (400) @(posedge clk);
    chk_state(4'h1);
    rd_reg(OFS_OUT_AC);
    chk_reg(rdVal, 32'h00000222);
    wr_reg(OFS_CMD, 32'h00000002);
    chk_state(4'h0);
    // Delay of 50 ticks outlasts the poll bound, so only the bypass can finish
    wr_reg(OFS_DELAY, 32'h00000032);
    wr_reg(OFS_CTRL, mkCtrl(0, 1, 0, 0, 0));
    wr_reg(OFS_CMD, 32'h00000001);
    kick(1'b1);
    wait_state(4'h2);
    wr_reg(OFS_CMD, 32'h00000020);
    wait_state(4'h0);
    wr_reg(OFS_CMD, 32'h00000001);
    kick(1'b1);
    wait_state(4'h2);
    wr_reg(OFS_CMD, 32'h00000002);
    chk_state(4'h0);
    // Pulse: three active periods, then back to base values
    wr_reg(OFS_DELAY, 32'h00000000);
    wr_reg(defA(DEF_TRIG_AC), 32'h00000100);
    wr_reg(defA(DEF_START_PH), 32'h00000000);
    wr_reg(defA(DEF_END_PH), 32'h00000000);
    wr_reg(defA(DEF_ACT), 32'h00000002);
    wr_reg(defA(DEF_INACT), 32'h00000001);
    wr_reg(defA(DEF_COUNT), 32'h00000003);
    wr_reg(OFS_CTRL, mkCtrl(0, 2, 2, 0, 1));
    wr_reg(OFS_CMD, 32'h00000001);
    pulseBase = pulseCnt;
    wr_reg(OFS_CMD, 32'h00000010);
    wait_state(4'h0);
    repeat (210) @(posedge clk);
    chk_cnt(pulseCnt - pulseBase, 3);
    rd_reg(OFS_OUT_AC);
    chk_reg(rdVal, 32'h00000011);
    // Save to cell 1, overwrite, restore
    wr_reg(defA(DEF_TRIG_AC), 32'h00000abc);
    wr_reg(OFS_CMD, 32'h00000140);
    wr_reg(defA(DEF_TRIG_AC), 32'h00000def);
    wr_reg(OFS_CMD, 32'h00000180);
    rd_reg(defA(DEF_TRIG_AC));
    chk_reg(rdVal, 32'h00000abc);
    // List, one entry per panel trigger; second entry slews, strobe counts frequency moves
    wr_reg(defA(DEF_COUNT), 32'h00000001);
    wr_reg(OFS_LIST_LEN, 32'h00000002);
    wr_ent(3'h0, 16'h0040, 16'h0000, 16'h0010, 16'h0000);
    wr_ent(3'h1, 16'h0080, 16'h0007, 16'h0030, 16'h0010);
    wr_reg(OFS_CTRL, mkCtrl(0, 3, 1, 2, 0) | 32'(1 << CTRL_LSTEP));
    wr_reg(OFS_CMD, 32'h00000001);
    toutBase = toutCnt;
    kick(1'b0);
    wait_state(4'h8);
    chk_reg(32'(rdVal[6:4]), 32'h00000001);
    rd_reg(OFS_OUT_AC);
    chk_reg(rdVal, 32'h00000040);
    kick(1'b0);
    wait_state(4'h0);
    rd_reg(OFS_OUT_AC);
    chk_reg(rdVal, 32'h00000050);
    repeat (1000) @(posedge clk);
    rd_reg(OFS_OUT_AC);
    chk_reg(rdVal, 32'h00000080);
    chk_reg(32'(dcOffset), 32'h00000007);
    chk_reg(32'(outFreq), 32'h00000030);
    chk_cnt(toutCnt - toutBase, 3);
    // Abort, device reset and recall each force idle
    for (int b = 1; b < 4; b++) begin
      wr_reg(OFS_CMD, 32'h00000001);
      chk_state(4'h1);
      wr_reg(OFS_CMD, 32'(1 << b));
      chk_state(4'h0);
    end
    complete_run();
  end
endmodule : tb_top
